// ---- hdl/aof_formatter.sv ----
// Purpose: Output formatter for a 12-bit sampling converter.
// Assumes: clk_sys_i is the encode clock; the core hands one code per edge.
// Notes: Straps and sync are pins and pass the three-stage synchroniser.
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
// Function
// - Format strap selects two's complement or offset
// - Mode strap selects dual ports or differential
// - Arrangement strap: parallel rising, or split edges
// - Interleaved ports change half clock apart
// - Sync aligns A earlier, B later sample
// - Differential mode ignores the sync input
// - Port B carries 12 bits plus overrange
// - Port A carries 12 bits, same coding
// - Differential word on true/complement pairs
// - Differential overrange as true/complement pair
// - Unconnected straps read low by default
// - One sample per rising encode edge
// - Dual mode data clock is encode halved
// - Differential data clock toggles at encode rate
// - Latency 14/14 interleaved, 14/15 parallel
module aof_formatter
(
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Conversion core result.
	input wire logic [11:0] core_code_i,
	input wire logic core_over_i,
	// Mode straps.
	input wire logic format_select_strap_i,
	input wire logic output_mode_strap_i,
	input wire logic port_arrangement_strap_i,
	input wire logic full_scale_strap_i,
	// Data sync pair.
	input wire logic sync_in_true_i,
	input wire logic sync_in_comp_i,
	// Dual single-ended ports.
	output logic [11:0] port_a_o,
	output logic or_a_o,
	output logic [11:0] port_b_o,
	output logic or_b_o,
	// Differential bus.
	output logic [11:0] diff_true_o,
	output logic [11:0] diff_comp_o,
	output logic or_true_o,
	output logic or_comp_o,
	// Data clock pair and pipeline status.
	output logic data_clock_out_true_o,
	output logic data_clock_out_comp_o,
	output logic data_valid_o,
	// Register port.
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic irq_o
);
	// One pipeline word: overrange above the code.
	typedef logic [12:0] aof_word_t;

	// All state of the formatter.
	typedef struct packed {
		aof_word_t [aof_pkg::PIPE_D-1:0] pipe;
		logic phase;
		logic [11:0] port_a;
		logic or_a;
		logic [11:0] port_b;
		logic or_b;
		logic [11:0] diff_t;
		logic [11:0] diff_c;
		logic or_t;
		logic or_c;
		logic dco_t;
		logic dco_c;
		logic [aof_pkg::STRAP_W-1:0] strap_q;
		logic sync_q;
		logic [4:0] fill;
		logic valid;
		logic [aof_pkg::ST_W-1:0] status;
		logic [aof_pkg::ST_W-1:0] mask;
		logic [7:0] rdata;
		logic irq;
	} aof_st_t;

	aof_st_t st;
	aof_st_t next_st;

	// Synchronised strap levels.
	logic [aof_pkg::STRAP_W-1:0] strap;
	// Synchronised sync pair.
	logic [1:0] sync_lvl;

	// Straps read low until a driven high level settles.
	aof_pin_sync #(
		.W(aof_pkg::STRAP_W)
	) u_strap_sync (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.pin_i({full_scale_strap_i, port_arrangement_strap_i,
			output_mode_strap_i, format_select_strap_i}),
		.level_o(strap)
	);

	// The sync pair is another asynchronous pin group.
	aof_pin_sync #(
		.W(2)
	) u_ds_sync (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.pin_i({sync_in_comp_i, sync_in_true_i}),
		.level_o(sync_lvl)
	);

	// Decoded modes from the settled straps.
	logic twos;
	logic dual;
	logic inter;
	// Sync asserted when true is high and complement low.
	logic sync_on;
	// Rising edge of the settled sync level.
	logic sync_edge;
	// Words taken from the two pipeline taps.
	aof_word_t tap_main;
	aof_word_t tap_long;

	assign twos = strap[aof_pkg::STRAP_FMT];
	assign dual = !strap[aof_pkg::STRAP_MODE];
	assign inter = strap[aof_pkg::STRAP_ARR];
	// An idle pair, true low and complement high, never asserts.
	assign sync_on = sync_lvl[0] && !sync_lvl[1];
	assign sync_edge = sync_on && !st.sync_q;
	assign tap_main = st.pipe[aof_pkg::LAT_MAIN-2];
	assign tap_long = st.pipe[aof_pkg::LAT_LONG-2];

	// Recode a raw offset binary code; two's complement flips the MSB.
	function automatic logic [11:0] fmt(input logic [11:0] code,
		input logic tc);
		fmt = {code[11] ^ tc, code[10:0]};
	endfunction

	// Next-state logic for pipeline, ports, clock and registers.
	always_comb
	begin
		next_st = st;
		// Capture one code per rising encode edge.
		next_st.pipe[0] = {core_over_i, core_code_i};
		for (int i = 1; i < aof_pkg::PIPE_D; i++)
		begin
			next_st.pipe[i] = st.pipe[i-1];
		end
		// The output clock toggles every encode cycle; a dual-mode sync edge can hold it once.
		next_st.dco_t = st.phase;
		next_st.dco_c = !st.phase;
		next_st.phase = !st.phase;
		next_st.sync_q = sync_on;
		if (dual)
		begin
			// Differential drivers are parked low.
			next_st.diff_t = '0;
			next_st.diff_c = '0;
			next_st.or_t = 1'b0;
			next_st.or_c = 1'b0;
			// Sync restarts the pair so A holds the earlier word.
			if (sync_edge)
			begin
				next_st.phase = 1'b0;
			end
			if (inter)
			begin
				// A moves on the falling clock edge, B on the rising.
				if (!st.phase)
				begin
					// Port A, 14 cycles latency.
					next_st.port_a = fmt(tap_main[11:0], twos);
					next_st.or_a = tap_main[12];
				end
				else
				begin
					// Port B, 14 cycles latency.
					next_st.port_b = fmt(tap_main[11:0], twos);
					next_st.or_b = tap_main[12];
				end
			end
			else if (st.phase)
			begin
				// Both ports move on the rising clock edge.
				next_st.port_a = fmt(tap_long[11:0], twos);
				next_st.or_a = tap_long[12];
				next_st.port_b = fmt(tap_main[11:0], twos);
				next_st.or_b = tap_main[12];
			end
		end
		else
		begin
			// Dual ports are parked low; sync has no effect here.
			next_st.port_a = '0;
			next_st.or_a = 1'b0;
			next_st.port_b = '0;
			next_st.or_b = 1'b0;
			// One word per encode cycle on complementary pairs.
			next_st.diff_t = fmt(tap_main[11:0], twos);
			next_st.diff_c = ~fmt(tap_main[11:0], twos);
			// Overrange travels beside the word.
			next_st.or_t = tap_main[12];
			next_st.or_c = !tap_main[12];
		end
		// A strap change restarts the refill count.
		next_st.strap_q = strap;
		if (strap != st.strap_q)
		begin
			next_st.fill = '0;
			next_st.valid = 1'b0;
		end
		else if (st.fill != aof_pkg::FILL_CYC)
		begin
			next_st.fill = st.fill + 5'h01;
		end
		else
		begin
			next_st.valid = 1'b1;
		end
		// Register read: data stand in the following cycle only.
		next_st.rdata = '0;
		if (reg_rd_i)
		begin
			if (reg_addr_i == aof_pkg::REG_STATUS)
			begin
				next_st.rdata = 8'({st.status});
				next_st.status = '0;
			end
			else if (reg_addr_i == aof_pkg::REG_MASK)
			begin
				next_st.rdata = 8'({st.mask});
			end
			else if (reg_addr_i == aof_pkg::REG_CONFIG)
			begin
				next_st.rdata = 8'({st.valid, strap});
			end
		end
		// Mask is the one writable register.
		if (reg_wr_i && reg_addr_i == aof_pkg::REG_MASK)
		begin
			next_st.mask = reg_wdata_i[aof_pkg::ST_W-1:0];
		end
		// Events set sticky bits after the clear, so a set wins.
		if (st.valid && (st.or_a || st.or_b || st.or_t))
		begin
			next_st.status[aof_pkg::ST_OVER] = 1'b1;
		end
		if (dual && sync_edge)
		begin
			next_st.status[aof_pkg::ST_SYNC] = 1'b1;
		end
		if (strap != st.strap_q)
		begin
			next_st.status[aof_pkg::ST_CFG] = 1'b1;
		end
		next_st.irq = |(next_st.status & next_st.mask);
	end

	// Register the whole state; phase starts high so the clock toggles at once.
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st <= '0;
			st.phase <= 1'b1;
			st.dco_c <= 1'b1;
			st.mask <= aof_pkg::MASK_RST;
		end
		else
		begin
			st <= next_st;
		end
	end

	// Every output is a flip-flop of the state.
	assign port_a_o = st.port_a;
	assign or_a_o = st.or_a;
	assign port_b_o = st.port_b;
	assign or_b_o = st.or_b;
	assign diff_true_o = st.diff_t;
	assign diff_comp_o = st.diff_c;
	assign or_true_o = st.or_t;
	assign or_comp_o = st.or_c;
	assign data_clock_out_true_o = st.dco_t;
	assign data_clock_out_comp_o = st.dco_c;
	assign data_valid_o = st.valid;
	assign reg_rdata_o = st.rdata;
	assign irq_o = st.irq;

	// Checks run on the encode clock and rest during reset.
	default clocking aof_cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	// Straps have been steady long enough for checks on the data path.
	logic steady;
	assign steady = st.valid && strap == st.strap_q;

	// Differential word carries the chosen coding, 14 cycles late.
	diff_lat_a: assert property (
		steady && !dual && $past(steady, 1) && $past(!dual, 1)
		|=> diff_true_o == fmt($past(core_code_i, 14), $past(twos, 1)))
		else $error("differential word wrong coding or latency");

	// Complement bus mirrors the true bus in differential mode.
	diff_pair_a: assert property (
		$past(!dual, 1) && $past(steady, 1)
		|-> diff_comp_o == ~diff_true_o && or_comp_o == !or_true_o)
		else $error("differential complement not inverted");

	// Dual ports stay parked while differential mode runs.
	port_idle_a: assert property (
		!dual && $past(!dual, 1) |=> port_a_o == '0 && port_b_o == '0)
		else $error("dual ports driven in differential mode");

	// Data clock toggles on every encode edge; only a sync may hold it once.
	dco_toggle_a: assert property (
		$past(rst_n_i, 1) && !$past(dual && sync_edge, 2)
		|-> data_clock_out_true_o != $past(data_clock_out_true_o)
		&& data_clock_out_comp_o == !data_clock_out_true_o)
		else $error("data clock failed to toggle");

	// Interleaved port A never moves on a rising clock edge.
	inter_a_hold_a: assert property (
		steady && dual && inter && $rose(data_clock_out_true_o)
		|-> $stable(port_a_o))
		else $error("interleaved port A moved with port B");

	// Parallel port B shows the sample from 14 cycles back.
	par_b_lat_a: assert property (
		steady && dual && !inter && $past(steady, 1)
		&& $rose(data_clock_out_true_o)
		|-> port_b_o == fmt($past(core_code_i, 14), twos)
		&& or_b_o == $past(core_over_i, 14))
		else $error("parallel port B latency or overrange wrong");

	// Parallel port A holds the earlier sample, 15 cycles back.
	par_a_lat_a: assert property (
		steady && dual && !inter && $past(steady, 1)
		&& $rose(data_clock_out_true_o)
		|-> port_a_o == fmt($past(core_code_i, 15), twos))
		else $error("parallel port A not the earlier sample");

	// A sync edge in dual mode lands the clock low two edges later.
	sync_align_a: assert property (
		dual && sync_edge |=> ##1 !data_clock_out_true_o)
		else $error("sync did not realign the pair");

	// A strap change drops the valid flag at once.
	cfg_refill_a: assert property (
		strap != st.strap_q |=> !data_valid_o [*8])
		else $error("valid flag held across strap change");

	// An unmasked overrange at an output raises the interrupt next edge.
	irq_mask_a: assert property (
		st.valid && (or_a_o || or_b_o || or_true_o)
		&& st.mask[aof_pkg::ST_OVER] && !reg_wr_i |=> irq_o)
		else $error("interrupt missed an unmasked overrange");
endmodule // aof_formatter

// ---- hdl/aof_pkg.sv ----
// Purpose: Shared constants for the converter output port formatter.
// Assumes: One encode clock domain; straps and sync arrive as raw pins.
// Notes: Register offsets, field positions and pipeline counts live here.
package aof_pkg;
	// Width of one sample word.
	localparam int unsigned SAMPLE_W = 12;
	// Encode cycles from sampling edge to output for the common path.
	localparam int unsigned LAT_MAIN = 14;
	// Encode cycles to output for the earlier word of a parallel pair.
	localparam int unsigned LAT_LONG = 15;
	// Pipeline depth; the output register adds the last stage.
	localparam int unsigned PIPE_D = LAT_LONG - 1;
	// Cycles of refill after a configuration change.
	localparam logic [4:0] FILL_CYC = 5'h0f;
	// Strap bit positions inside the synchronised strap vector.
	localparam int unsigned STRAP_FMT = 0;
	localparam int unsigned STRAP_MODE = 1;
	localparam int unsigned STRAP_ARR = 2;
	localparam int unsigned STRAP_FS = 3;
	localparam int unsigned STRAP_W = 4;
	// Register offsets on the plain register port.
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_MASK = 4'h1;
	localparam logic [3:0] REG_CONFIG = 4'h2;
	// Status and mask bit positions.
	localparam int unsigned ST_OVER = 0;
	localparam int unsigned ST_SYNC = 1;
	localparam int unsigned ST_CFG = 2;
	localparam int unsigned ST_W = 3;
	// Reset value of the interrupt mask: all events masked.
	localparam logic [2:0] MASK_RST = 3'h0;
	// Config register field: refill done flag position.
	localparam int unsigned CFG_VALID = 4;
endpackage

// ---- hdl/aof_pin_sync.sv ----
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Input is asynchronous to clk_sys_i.
// Notes: The output moves only when stages two and three agree.
`timescale 1ns/1ps
module aof_pin_sync #(
	parameter int unsigned W = 1
)
(
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Raw pin levels.
	input wire logic [W-1:0] pin_i,
	// Filtered levels.
	output logic [W-1:0] level_o
);
	// All state of the synchroniser.
	typedef struct packed {
		logic [W-1:0] ff1;
		logic [W-1:0] ff2;
		logic [W-1:0] ff3;
		logic [W-1:0] lvl;
	} aof_sync_st_t;

	aof_sync_st_t st;
	aof_sync_st_t next_st;

	// Shift the chain; the first stage feeds only the second.
	always_comb
	begin
		next_st = st;
		next_st.ff1 = pin_i;
		next_st.ff2 = st.ff1;
		next_st.ff3 = st.ff2;
		// Accept a change only once two settled stages agree.
		for (int i = 0; i < W; i++)
		begin
			if (st.ff2[i] == st.ff3[i])
			begin
				next_st.lvl[i] = st.ff3[i];
			end
		end
	end

	// Register the state; low after reset, matching the pulldowns.
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign level_o = st.lvl;
endmodule // aof_pin_sync

// ---- verification/aof_rx_model.sv ----
// Purpose: Receiving side model that drives the sync pair and counts words.
// Assumes: The sync request changes just after a rising clock edge.
// Notes: One word pair is captured per rising data clock while valid.
`timescale 1ns/1ps
module aof_rx_model
(
	// Clock and sync request.
	input wire logic clk_sys_i,
	input wire logic sync_req_i,
	// Data clock and valid from the block.
	input wire logic dck_i,
	input wire logic valid_i,
	// Sync pair towards the block.
	output logic sync_true_o,
	output logic sync_comp_o,
	// Count of captured word pairs.
	output int cap_cnt_o = 0
);
	// Previous data clock level, used to find its rising edge.
	logic dck_q = 1'b0;
	// An idle sync pair rests low on true and high on complement.
	assign sync_true_o = sync_req_i;
	assign sync_comp_o = !sync_req_i;
	// Capture happens on the rising data clock only.
	always @(posedge clk_sys_i)
	begin
		if (valid_i && dck_i && !dck_q)
			cap_cnt_o <= cap_cnt_o + 1;
		dck_q <= dck_i;
	end
endmodule // aof_rx_model

// ---- verification/aof_formatter_tb_top.sv ----
// Purpose: Self-checking bench for the converter output formatter.
// Assumes: Core codes are random; straps change only between tests.
// Notes: A ring of recent samples gives every expected port word.
`timescale 1ns/1ps
module aof_formatter_tb_top;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [11:0] code = 12'h000;
	logic over = 1'b0;
	logic [3:0] strap = 4'h0; // Order is {fs, arr, mode, fmt}.
	logic sync_req = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [11:0] pa, pb, dt, dc;
	logic ora, orb, ort, orc, dck, dckc, vld, irq, st, sc;
	logic [7:0] rdata;
	logic [12:0] hist [32]; // Recent {over, code} pairs by cycle.
	logic prev_dck = 1'b0;
	bit run_chk = 1'b0;
	bit over_rnd = 1'b0;
	bit over_one = 1'b0;
	int cyc = 0;
	int err_total = 0;
	int checks_done = 0;
	int cap;
	// The clock inverts every half period of 2 ns.
	always #2 clk_sys_i = ~clk_sys_i;
	aof_formatter i_dut
	(
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.core_code_i(code), .core_over_i(over),
		.format_select_strap_i(strap[0]), .output_mode_strap_i(strap[1]),
		.port_arrangement_strap_i(strap[2]), .full_scale_strap_i(strap[3]),
		.sync_in_true_i(st), .sync_in_comp_i(sc),
		.port_a_o(pa), .or_a_o(ora), .port_b_o(pb), .or_b_o(orb),
		.diff_true_o(dt), .diff_comp_o(dc), .or_true_o(ort), .or_comp_o(orc),
		.data_clock_out_true_o(dck), .data_clock_out_comp_o(dckc),
		.data_valid_o(vld), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq)
	);
	aof_rx_model i_rx
	(
		.clk_sys_i(clk_sys_i), .sync_req_i(sync_req), .dck_i(dck),
		.valid_i(vld), .sync_true_o(st), .sync_comp_o(sc), .cap_cnt_o(cap)
	);
	// Counts a comparison and reports a mismatch at once.
	task automatic cmp(string what, logic [12:0] exp, logic [12:0] got);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %s exp %h got %h", what, exp, got);
		end
	endtask
	// Offset binary is the raw code; two's complement flips the top bit.
	function automatic logic [12:0] expw(int k);
		logic [12:0] h;
		h = hist[k & 31];
		return strap[0] ? (h ^ 13'h0800) : h;
	endfunction
	// Records each sample, drives the next one and checks the outputs.
	always @(posedge clk_sys_i)
	begin
		// Seed the stimulus generator once, before any test runs.
		if (cyc == 0)
			void'($urandom(26));
		hist[cyc & 31] = {over, code};
		if (run_chk && vld === 1'b1)
		begin
			cmp("dck", 13'(!prev_dck), 13'(dck));
			cmp("dckc", 13'(!dck), 13'(dckc));
			if (strap[1])
			begin
				cmp("diff", expw(cyc - 14), {ort, dt});
				cmp("diffc", ~expw(cyc - 14), {orc, dc});
				cmp("pa_off", 13'h0000, {ora, pa});
				cmp("pb_off", 13'h0000, {orb, pb});
			end
			else
			begin
				cmp("diff_off", 13'h0000, {ort, dt});
				if (dck && !prev_dck)
					cmp("pb", expw(cyc - 14), {orb, pb});
				if (dck && !prev_dck && !strap[2])
					cmp("pa", expw(cyc - 15), {ora, pa});
				if (!dck && prev_dck && strap[2])
					cmp("pa", expw(cyc - 14), {ora, pa});
			end
		end
		prev_dck = dck;
		cyc++;
		code <= 12'($urandom);
		over <= over_one | (over_rnd && $urandom_range(7) == 0);
	end
	task automatic reg_wr(logic [3:0] a, logic [7:0] d);
		@(posedge clk_sys_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys_i);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe.
	task automatic reg_chk(string what, logic [3:0] a, logic [7:0] exp);
		@(posedge clk_sys_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_i);
		rd <= 1'b0;
		#1 cmp(what, {5'h00, exp}, {5'h00, rdata});
	endtask
	task automatic wait_vld();
		int n;
		n = 0;
		while (vld !== 1'b1 && n < 80)
		begin
			@(posedge clk_sys_i);
			n++;
		end
		cmp("valid", 13'h0001, 13'(vld));
		repeat (2) @(posedge clk_sys_i);
		run_chk = 1'b1;
	endtask
	// A strap change must drop valid until the pipeline refills.
	task automatic set_mode(logic [3:0] s);
		run_chk = 1'b0;
		@(posedge clk_sys_i);
		strap <= s;
		repeat (8) @(posedge clk_sys_i);
		cmp("vld_drop", 13'h0000, 13'(vld));
		wait_vld();
	endtask
	task automatic pulse_sync();
		@(posedge clk_sys_i);
		sync_req <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		sync_req <= 1'b0;
		repeat (12) @(posedge clk_sys_i);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Cuts a hang short well beyond the expected run length.
	initial
	begin
		repeat (6000) @(posedge clk_sys_i);
		err_total++;
		$display("[ERR] watchdog exp end got hang");
		stop_test();
	end
	initial
	begin
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		wait_vld();
		reg_chk("cfg", aof_pkg::REG_CONFIG, 8'h10);
		reg_chk("mask", aof_pkg::REG_MASK, {5'h00, aof_pkg::MASK_RST});
		reg_chk("unmapped", 4'h7, 8'h00);
		reg_wr(aof_pkg::REG_CONFIG, 8'h0f);
		reg_chk("cfg_ro", aof_pkg::REG_CONFIG, 8'h10);
		cmp("irq_off", 13'h0000, 13'(irq));
		repeat (40) @(posedge clk_sys_i);
		$display("test defaults done");
		over_rnd = 1'b1;
		for (int m = 1; m < 16; m++)
		begin
			set_mode(m[3:0]);
			repeat (40) @(posedge clk_sys_i);
			reg_chk("cfg", aof_pkg::REG_CONFIG, {4'h1, m[3:0]});
			$display("test mode %0d done", m);
		end
		over_rnd = 1'b0;
		run_chk = 1'b0;
		repeat (20) @(posedge clk_sys_i);
		reg_chk("st_clr", aof_pkg::REG_STATUS, 8'h05);
		pulse_sync();
		reg_chk("st_diff", aof_pkg::REG_STATUS, 8'h00);
		reg_wr(aof_pkg::REG_MASK, 8'h01);
		@(posedge clk_sys_i);
		over_one <= 1'b1;
		@(posedge clk_sys_i);
		over_one <= 1'b0;
		repeat (20) @(posedge clk_sys_i);
		cmp("irq_over", 13'h0001, 13'(irq));
		reg_chk("st_over", aof_pkg::REG_STATUS, 8'h01);
		repeat (2) @(posedge clk_sys_i);
		cmp("irq_clr", 13'h0000, 13'(irq));
		reg_wr(aof_pkg::REG_MASK, 8'h02);
		reg_chk("mask_rb", aof_pkg::REG_MASK, 8'h02);
		set_mode(4'h0);
		run_chk = 1'b0;
		reg_chk("st_cfg", aof_pkg::REG_STATUS, 8'h04);
		cmp("irq_msk", 13'h0000, 13'(irq));
		pulse_sync();
		cmp("irq_sync", 13'h0001, 13'(irq));
		reg_chk("st_sync", aof_pkg::REG_STATUS, 8'h02);
		run_chk = 1'b1;
		repeat (40) @(posedge clk_sys_i);
		cmp("captures", 1, 13'(cap > 0));
		$display("test events done");
		stop_test();
	end
endmodule // aof_formatter_tb_top
